// >>> rtl/cdp_pkg.sv
// Shared constants, instruction field layouts and carrier types for the core datapath.
// Assumes a 16-bit instruction word and a 6-bit I/O space outside the core.
`default_nettype none

package cdp_pkg;

  localparam int PC_W        = 9;
  localparam int DATA_W      = 8;
  localparam int IO_AW       = 6;
  localparam int RA_W        = 5;
  localparam int NREG        = 32;
  localparam int STACK_DEPTH = 3;

  localparam logic [8:0] PC_RESET      = 9'h000;
  localparam logic [7:0] FLAGS_RESET   = 8'h00;
  localparam logic [5:0] IO_FLAGS_ADDR = 6'h3F;
  localparam logic [4:0] PTR_LO_REG    = 5'h1E;
  localparam logic [4:0] PTR_HI_REG    = 5'h1F;
  localparam logic [7:0] IND_IO_BASE   = 8'h20;
  localparam logic [7:0] IND_IO_LAST   = 8'h5F;
  localparam logic [7:0] ONE_BYTE      = 8'h01;

  // Major opcodes, instruction bits 15..12
  localparam logic [3:0] OP_ARITH = 4'h0;
  localparam logic [3:0] OP_LOGIC = 4'h1;
  localparam logic [3:0] OP_CMP   = 4'h2;
  localparam logic [3:0] OP_SUBTRACT_IMMEDIATE_INSTR  = 4'h3;
  localparam logic [3:0] OP_SUBTRACT_CARRY_IMMEDIATE_INSTR  = 4'h4;
  localparam logic [3:0] OP_CPI   = 4'h5;
  localparam logic [3:0] OP_AND_IMMEDIATE_INSTR  = 4'h6;
  localparam logic [3:0] OP_ORI   = 4'h7;
  localparam logic [3:0] OP_MISC  = 4'h8;
  localparam logic [3:0] OP_IOMOV = 4'h9;
  localparam logic [3:0] OP_IOBIT = 4'hA;
  localparam logic [3:0] OP_RJMP  = 4'hC;
  localparam logic [3:0] OP_RELATIVE_CALL_INSTR = 4'hD;
  localparam logic [3:0] OP_LDI   = 4'hE;

  // Two-register sub-ops: ARITH add/adc/sub/sbc, LOGIC and/or/eor/mov, CMP cp/cpc
  localparam logic [1:0] RS_AND = 2'h0;
  localparam logic [1:0] RS_OR  = 2'h1;
  localparam logic [1:0] RS_EOR = 2'h2;
  localparam logic [1:0] RS_MOV = 2'h3;

  // Single-register and miscellaneous sub-ops
  localparam logic [3:0] MS_INC  = 4'h0;
  localparam logic [3:0] MS_DEC  = 4'h1;
  localparam logic [3:0] MS_LSR  = 4'h2;
  localparam logic [3:0] MS_LD   = 4'h3;
  localparam logic [3:0] MS_ST   = 4'h4;
  localparam logic [3:0] MS_LPM  = 4'h5;
  localparam logic [3:0] MS_BST  = 4'h6;
  localparam logic [3:0] MS_BLD  = 4'h7;
  localparam logic [3:0] MS_RET  = 4'h8;
  localparam logic [3:0] MS_INTERRUPT_RETURN_INSTR = 4'h9;

  // I/O bit sub-ops
  localparam logic [1:0] BS_SET   = 2'h0;
  localparam logic [1:0] BS_CLR   = 2'h1;
  localparam logic [1:0] BS_SKIPS = 2'h2;
  localparam logic [1:0] BS_SKIPC = 2'h3;

  typedef struct packed {
    logic [3:0] op;
    logic [1:0] sub;
    logic [4:0] d;
    logic [4:0] r;
  } cdp_rr_s;

  typedef struct packed {
    logic [3:0] op;
    logic [3:0] d;
    logic [7:0] k;
  } cdp_imm_s;

  typedef struct packed {
    logic [3:0] op;
    logic [3:0] sub;
    logic [2:0] bitn;
    logic [4:0] d;
  } cdp_misc_s;

  typedef struct packed {
    logic [3:0] op;
    logic       out;
    logic [5:0] a;
    logic [4:0] d;
  } cdp_iomov_s;

  typedef struct packed {
    logic [3:0] op;
    logic [1:0] sub;
    logic [4:0] a;
    logic [1:0] pad;
    logic [2:0] bitn;
  } cdp_iobit_s;

  typedef struct packed {
    logic [3:0]  op;
    logic [11:0] k;
  } cdp_rel_s;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } cdp_ptr_s;

  typedef struct packed {
    logic i;
    logic t;
    logic h;
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
  } cdp_flags_s;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } cdp_io_req_s;

  typedef enum logic {
    PIPE_FLUSHED,
    PIPE_FULL
  } cdp_pipe_e;

  function automatic logic cdp_is_imm_op(input logic [3:0] op);
    return (op == OP_SUBTRACT_IMMEDIATE_INSTR) || (op == OP_SUBTRACT_CARRY_IMMEDIATE_INSTR) || (op == OP_CPI) || (op == OP_AND_IMMEDIATE_INSTR) ||
           (op == OP_ORI) || (op == OP_LDI);
  endfunction

endpackage

`default_nettype wire

// >>> rtl/cdp_regfile.sv
// Working register file: two combinational read ports, one write port, pointer pair out.
// Assumes one clock; contents are left untouched by reset.
`default_nettype none

module cdp_regfile #(
  parameter int NREG = cdp_pkg::NREG,
  parameter int AW   = cdp_pkg::RA_W
) (
  input  wire logic             ref_clk,
  input  wire logic [AW-1:0]    rd_addr_a,
  output logic [7:0]            rd_data_a,
  input  wire logic [AW-1:0]    rd_addr_b,
  output logic [7:0]            rd_data_b,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [7:0]       wr_data,
  output cdp_pkg::cdp_ptr_s     ptr
);

  if (NREG != (1 << AW) || NREG < 32) begin : g_bad_size
    $error("cdp_regfile: NREG must be 2**AW and at least 32");
  end

  logic [7:0] regs [NREG];

  assign rd_data_a = regs[rd_addr_a];
  assign rd_data_b = regs[rd_addr_b];
  assign ptr.lo    = regs[cdp_pkg::PTR_LO_REG];
  assign ptr.hi    = regs[cdp_pkg::PTR_HI_REG];

  // Written at the end of the same cycle that read the operands
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      regs[wr_addr] <= wr_data;
    end
  end

endmodule // cdp_regfile

`default_nettype wire

// >>> rtl/cdp_core.sv
// Execution core: decode, ALU, flags, program counter, return stack, I/O access.
// Assumes program memory and I/O space answer combinationally in the cycle addressed.
//
// Behaviour
// - Immediate instructions can only name registers 16 to 31.
// - All other register instructions reach any register in one cycle.
// - Registers 30 and 31 form the pointer; high byte ignored for register access.
// - Indirect register access selects the register by the pointer low byte.
// - Nine-bit program counter over 512 sixteen-bit instruction words.
// - Two-register operations other than compares read both and write the first operand register.
// - I/O direct addressing takes a six-bit address from the instruction.
// - Relative jump and call go to program counter plus offset plus one.
// - Constant fetch uses pointer bits 9..1 as word, bit 0 picks byte.
// - Three-level, nine-bit return stack shared by calls and interrupts.
// - Call or interrupt writes level 0 and shifts older levels down.
// - Return loads counter from level 0 and shifts levels up.
// - Oldest entry lost past three pushes; deepest level kept on pop.
// - Read operands, compute and write back within one clock.
// - Next instruction fetched while current executes.
// - Register to I/O moves; bit set, clear and skip only below 0x20.
// - Flag bit 7 is interrupt enable, cleared on entry, set on interrupt return.
// - No interrupt is taken while the interrupt enable is clear.
// - Flag bit 6 is the bit copy store for bit store and load.
// - Sign flag always equals negative xor overflow.
// - Flags live at I/O 0x3F, read/write except the sign flag, reset to zero.
`default_nettype none

module cdp_core #(
  parameter int PC_W        = cdp_pkg::PC_W,
  parameter int STACK_DEPTH = cdp_pkg::STACK_DEPTH
) (
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  output logic [PC_W-1:0]        pm_addr,
  input  wire logic [15:0]       pm_rdata,
  output cdp_pkg::cdp_io_req_s   io_req,
  input  wire logic [7:0]        io_rdata,
  input  wire logic              irq_req,
  input  wire logic [PC_W-1:0]   irq_vector,
  output logic                   irq_ack,
  output cdp_pkg::cdp_flags_s    cpu_flags,
  output logic [PC_W-1:0]        program_counter
);

  // Offsets are added modulo the counter width, so it must not exceed the offset field
  if (PC_W < 1 || PC_W > 12 || STACK_DEPTH < 2) begin : g_bad_param
    $error("cdp_core: PC_W must be 1..12 and STACK_DEPTH at least 2");
  end

  logic [15:0]          ir_reg;
  logic [15:0]          ir_next;
  cdp_pkg::cdp_pipe_e   pipe_reg;
  cdp_pkg::cdp_pipe_e   pipe_next;
  logic [PC_W-1:0]      pc_reg;
  logic [PC_W-1:0]      pc_next;
  logic [PC_W-1:0]      epc_reg;
  logic [PC_W-1:0]      epc_next;
  cdp_pkg::cdp_flags_s  flags_reg;
  cdp_pkg::cdp_flags_s  flags_next;
  logic [PC_W-1:0]      stk_reg [STACK_DEPTH];

  cdp_pkg::cdp_rr_s     f_rr;
  cdp_pkg::cdp_imm_s    f_imm;
  cdp_pkg::cdp_misc_s   f_misc;
  cdp_pkg::cdp_iomov_s  f_io;
  cdp_pkg::cdp_iobit_s  f_bit;
  cdp_pkg::cdp_rel_s    f_rel;
  cdp_pkg::cdp_ptr_s    ptr;

  assign f_rr   = cdp_pkg::cdp_rr_s'(ir_reg);
  assign f_imm  = cdp_pkg::cdp_imm_s'(ir_reg);
  assign f_misc = cdp_pkg::cdp_misc_s'(ir_reg);
  assign f_io   = cdp_pkg::cdp_iomov_s'(ir_reg);
  assign f_bit  = cdp_pkg::cdp_iobit_s'(ir_reg);
  assign f_rel  = cdp_pkg::cdp_rel_s'(ir_reg);

  wire logic [3:0] op       = f_rr.op;
  wire logic       ex_valid = (pipe_reg == cdp_pkg::PIPE_FULL);
  wire logic       take_irq = ex_valid && flags_reg.i && irq_req;
  wire logic       run      = ex_valid && !take_irq;
  wire logic       imm_op   = cdp_pkg::cdp_is_imm_op(op);
  wire logic       rr_op    = (op == cdp_pkg::OP_ARITH) || (op == cdp_pkg::OP_LOGIC) ||
                              (op == cdp_pkg::OP_CMP);
  wire logic       is_misc  = run && (op == cdp_pkg::OP_MISC);
  wire logic [3:0] msub     = f_misc.sub;

  wire logic do_ld    = is_misc && (msub == cdp_pkg::MS_LD);
  wire logic do_st    = is_misc && (msub == cdp_pkg::MS_ST);
  wire logic do_lpm   = is_misc && (msub == cdp_pkg::MS_LPM);
  wire logic do_bst   = is_misc && (msub == cdp_pkg::MS_BST);
  wire logic do_bld   = is_misc && (msub == cdp_pkg::MS_BLD);
  wire logic do_interrupt_return_instr  = is_misc && (msub == cdp_pkg::MS_INTERRUPT_RETURN_INSTR);
  wire logic do_ret   = is_misc && ((msub == cdp_pkg::MS_RET) || do_interrupt_return_instr);
  wire logic do_rjmp  = run && (op == cdp_pkg::OP_RJMP);
  wire logic do_relative_call_instr = run && (op == cdp_pkg::OP_RELATIVE_CALL_INSTR);
  wire logic do_in    = run && (op == cdp_pkg::OP_IOMOV) && !f_io.out;
  wire logic do_out   = run && (op == cdp_pkg::OP_IOMOV) && f_io.out;
  wire logic do_iobit = run && (op == cdp_pkg::OP_IOBIT);
  wire logic bit_wr   = do_iobit && ((f_bit.sub == cdp_pkg::BS_SET) ||
                                     (f_bit.sub == cdp_pkg::BS_CLR));

  // Pointer: only the low byte matters when it names a register or I/O location
  wire logic [7:0] zl         = ptr.lo;
  wire logic       ind_is_reg = zl < cdp_pkg::IND_IO_BASE;
  wire logic       ind_is_io  = !ind_is_reg && (zl <= cdp_pkg::IND_IO_LAST);
  wire logic [7:0] ind_off    = zl - cdp_pkg::IND_IO_BASE;

  // Register file ports
  logic [4:0] ra;
  logic [4:0] rb;
  logic [7:0] rd_a;
  logic [7:0] rd_b;
  logic       rf_we;
  logic [4:0] rf_wa;
  logic [7:0] rf_wd;

  assign ra = imm_op ? {1'h1, f_imm.d} : (rr_op ? f_rr.d : f_misc.d);
  assign rb = (op == cdp_pkg::OP_MISC) ? zl[4:0] : f_rr.r;

  cdp_regfile #(
    .NREG (cdp_pkg::NREG),
    .AW   (cdp_pkg::RA_W)
  ) u_regfile (
    .ref_clk   (ref_clk),
    .rd_addr_a (ra),
    .rd_data_a (rd_a),
    .rd_addr_b (rb),
    .rd_data_b (rd_b),
    .wr_en     (rf_we),
    .wr_addr   (rf_wa),
    .wr_data   (rf_wd),
    .ptr       (ptr)
  );

  // I/O access
  wire logic [5:0] io_addr   = do_iobit ? {1'h0, f_bit.a} :
                               (op == cdp_pkg::OP_MISC) ? ind_off[5:0] : f_io.a;
  wire logic       io_rd     = do_in || do_iobit || (do_ld && ind_is_io);
  wire logic       io_wr     = do_out || bit_wr || (do_st && ind_is_io);
  wire logic       hit_flags = (io_addr == cdp_pkg::IO_FLAGS_ADDR);
  wire logic [7:0] io_val    = hit_flags ? flags_reg : io_rdata;
  wire logic [7:0] bit_mask  = cdp_pkg::ONE_BYTE << f_bit.bitn;
  wire logic [7:0] bit_mask_m = cdp_pkg::ONE_BYTE << f_misc.bitn;
  wire logic [7:0] io_wd     = !bit_wr ? rd_a :
                               (f_bit.sub == cdp_pkg::BS_SET) ? (io_val | bit_mask) :
                               (io_val & ~bit_mask);
  wire logic       flags_we  = io_wr && hit_flags;
  wire logic       io_bit    = io_val[f_bit.bitn];
  wire logic       skip      = do_iobit && (((f_bit.sub == cdp_pkg::BS_SKIPS) && io_bit) ||
                                            ((f_bit.sub == cdp_pkg::BS_SKIPC) && !io_bit));

  // Flags are held inside the core, never forwarded to the I/O space
  assign io_req.addr  = io_addr;
  assign io_req.wdata = io_wd;
  assign io_req.we    = io_wr && !hit_flags;
  assign io_req.re    = io_rd && !hit_flags;

  // ALU: one adder serves add, subtract, compare, increment and decrement
  logic       a_sub;
  logic       a_usec;
  logic [7:0] a_b;
  always_comb begin
    a_sub  = 1'h0;
    a_usec = 1'h0;
    a_b    = rd_b;
    case (op)
      cdp_pkg::OP_ARITH: begin
        a_sub  = f_rr.sub[1];
        a_usec = f_rr.sub[0];
      end
      cdp_pkg::OP_CMP: begin
        a_sub  = 1'h1;
        a_usec = f_rr.sub[0];
      end
      // Two-register logic takes its second operand from the file, not the word
      cdp_pkg::OP_LOGIC: a_b = rd_b;
      cdp_pkg::OP_SUBTRACT_IMMEDIATE_INSTR,
      cdp_pkg::OP_CPI: begin
        a_sub = 1'h1;
        a_b   = f_imm.k;
      end
      cdp_pkg::OP_SUBTRACT_CARRY_IMMEDIATE_INSTR: begin
        a_sub  = 1'h1;
        a_usec = 1'h1;
        a_b    = f_imm.k;
      end
      cdp_pkg::OP_MISC: begin
        a_sub = (msub == cdp_pkg::MS_DEC);
        a_b   = cdp_pkg::ONE_BYTE;
      end
      default: a_b = f_imm.k;
    endcase
  end

  wire logic [7:0] b_eff = a_sub ? ~a_b : a_b;
  wire logic       cin   = a_sub ^ (a_usec & flags_reg.c);
  wire logic [8:0] sum   = {1'h0, rd_a} + {1'h0, b_eff} + {8'h00, cin};
  wire logic [4:0] hsum  = {1'h0, rd_a[3:0]} + {1'h0, b_eff[3:0]} + {4'h0, cin};
  wire logic       s_v   = (rd_a[7] == b_eff[7]) && (sum[7] != rd_a[7]);
  wire logic       s_z   = (sum[7:0] == 8'h00) && (!a_usec || flags_reg.z);

  logic [7:0]          alu_res;
  logic                alu_we;
  cdp_pkg::cdp_flags_s alu_fl;
  logic                alu_upd;
  always_comb begin
    alu_res = sum[7:0];
    alu_we  = 1'h0;
    alu_upd = 1'h0;
    alu_fl  = flags_reg;
    case (op)
      cdp_pkg::OP_ARITH, cdp_pkg::OP_CMP, cdp_pkg::OP_SUBTRACT_IMMEDIATE_INSTR,
      cdp_pkg::OP_SUBTRACT_CARRY_IMMEDIATE_INSTR, cdp_pkg::OP_CPI: begin
        alu_we   = (op != cdp_pkg::OP_CMP) && (op != cdp_pkg::OP_CPI);
        alu_upd  = 1'h1;
        alu_fl.h = a_sub ^ hsum[4];
        alu_fl.c = a_sub ^ sum[8];
        alu_fl.v = s_v;
        alu_fl.n = sum[7];
        alu_fl.z = s_z;
      end
      cdp_pkg::OP_LOGIC, cdp_pkg::OP_AND_IMMEDIATE_INSTR, cdp_pkg::OP_ORI: begin
        if (op == cdp_pkg::OP_AND_IMMEDIATE_INSTR ||
            (op == cdp_pkg::OP_LOGIC && f_rr.sub == cdp_pkg::RS_AND)) begin
          alu_res = rd_a & a_b;
        end else if (op == cdp_pkg::OP_ORI || f_rr.sub == cdp_pkg::RS_OR) begin
          alu_res = rd_a | a_b;
        end else if (f_rr.sub == cdp_pkg::RS_EOR) begin
          alu_res = rd_a ^ a_b;
        end else begin
          alu_res = a_b;
        end
        alu_we   = 1'h1;
        alu_upd  = (op != cdp_pkg::OP_LOGIC) || (f_rr.sub != cdp_pkg::RS_MOV);
        alu_fl.v = 1'h0;
        alu_fl.n = alu_res[7];
        alu_fl.z = (alu_res == 8'h00);
      end
      cdp_pkg::OP_LDI: begin
        alu_res = f_imm.k;
        alu_we  = 1'h1;
      end
      cdp_pkg::OP_MISC: begin
        if (msub == cdp_pkg::MS_LSR) begin
          alu_res  = rd_a >> 1;
          alu_fl.c = rd_a[0];
          alu_fl.n = 1'h0;
          alu_fl.v = rd_a[0];
        end else begin
          alu_fl.v = s_v;
          alu_fl.n = sum[7];
        end
        alu_fl.z = (alu_res == 8'h00);
        alu_we   = (msub == cdp_pkg::MS_INC) || (msub == cdp_pkg::MS_DEC) ||
                   (msub == cdp_pkg::MS_LSR);
        alu_upd  = alu_we;
      end
      default: alu_we = 1'h0;
    endcase
  end

  // Register write-back, completed in the same cycle as the operand read
  always_comb begin
    rf_we = 1'h0;
    rf_wa = ra;
    rf_wd = alu_res;
    if (do_ld) begin
      rf_we = ind_is_reg || ind_is_io;
      rf_wd = ind_is_reg ? rd_b : io_val;
    end else if (do_st) begin
      rf_we = ind_is_reg;
      rf_wa = zl[4:0];
      rf_wd = rd_a;
    end else if (do_lpm) begin
      rf_we = 1'h1;
      rf_wd = zl[0] ? pm_rdata[15:8] : pm_rdata[7:0];
    end else if (do_bld) begin
      rf_we = 1'h1;
      rf_wd = flags_reg.t ? (rd_a | bit_mask_m) : (rd_a & ~bit_mask_m);
    end else if (do_in) begin
      rf_we = 1'h1;
      rf_wd = io_val;
    end else begin
      rf_we = run && alu_we;
    end
  end

  // Flags: software write, ALU update, interrupt entry and return
  always_comb begin
    flags_next = flags_reg;
    if (run && alu_upd) begin
      flags_next = alu_fl;
    end
    if (do_bst) begin
      flags_next.t = rd_a[f_misc.bitn];
    end
    if (flags_we) begin
      flags_next = cdp_pkg::cdp_flags_s'(io_wd);
    end
    if (do_interrupt_return_instr) begin
      flags_next.i = 1'h1;
    end
    if (take_irq) begin
      flags_next.i = 1'h0;
    end
    flags_next.s = flags_next.n ^ flags_next.v;
  end

  // Program counter and prefetch; pc_reg is the fetch address, one past epc_reg
  wire logic [15:0]     ptr_word = ptr >> 1;
  wire logic [PC_W-1:0] rel_tgt  = pc_reg + f_rel.k[PC_W-1:0];
  wire logic            push     = do_relative_call_instr || take_irq;
  wire logic [PC_W-1:0] push_pc  = take_irq ? epc_reg : pc_reg;

  assign pm_addr = do_lpm ? ptr_word[PC_W-1:0] : pc_reg;

  always_comb begin
    ir_next   = pm_rdata;
    pc_next   = pc_reg + 1'h1;
    epc_next  = pc_reg;
    pipe_next = cdp_pkg::PIPE_FULL;
    irq_ack   = take_irq;
    if (take_irq) begin
      pc_next   = irq_vector;
      pipe_next = cdp_pkg::PIPE_FLUSHED;
    end else if (do_rjmp || do_relative_call_instr) begin
      pc_next   = rel_tgt;
      pipe_next = cdp_pkg::PIPE_FLUSHED;
    end else if (do_ret) begin
      pc_next   = stk_reg[0];
      pipe_next = cdp_pkg::PIPE_FLUSHED;
    end else if (do_lpm) begin
      // Memory port was borrowed for the constant, so the fetch is repeated
      pc_next   = pc_reg;
      epc_next  = epc_reg;
      pipe_next = cdp_pkg::PIPE_FLUSHED;
    end else if (skip) begin
      pipe_next = cdp_pkg::PIPE_FLUSHED;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ir_reg    <= 16'h0000;
      pipe_reg  <= cdp_pkg::PIPE_FLUSHED;
      pc_reg    <= cdp_pkg::PC_RESET[PC_W-1:0];
      epc_reg   <= cdp_pkg::PC_RESET[PC_W-1:0];
      flags_reg <= cdp_pkg::FLAGS_RESET;
    end else begin
      ir_reg    <= ir_next;
      pipe_reg  <= pipe_next;
      pc_reg    <= pc_next;
      epc_reg   <= epc_next;
      flags_reg <= flags_next;
    end
  end

  // Return stack; a push past the depth drops the oldest, a pop keeps the deepest
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stk_reg[i] <= '0;
      end
    end else if (push) begin
      stk_reg[0] <= push_pc;
      for (int i = 1; i < STACK_DEPTH; i++) begin
        stk_reg[i] <= stk_reg[i-1];
      end
    end else if (do_ret) begin
      for (int i = 0; i < STACK_DEPTH - 1; i++) begin
        stk_reg[i] <= stk_reg[i+1];
      end
    end
  end

  assign cpu_flags       = flags_reg;
  assign program_counter = epc_reg;

endmodule // cdp_core

`default_nettype wire

// >>> sim/cdp_mem_model.sv
// Program store and I/O space answering the core in the cycle addressed.
// Assumes the bench preloads mem and io through the hierarchy while reset is held.
`default_nettype none

module cdp_mem_model (
  input  wire logic                 ref_clk,
  input  wire logic [8:0]           pm_addr,
  output logic [15:0]               pm_rdata,
  input  wire cdp_pkg::cdp_io_req_s io_req,
  output logic [7:0]                io_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] mem [512];
  logic [7:0]  io  [64];

  assign pm_rdata = mem[pm_addr];
  // Without a read strobe the data is inverted, so a core that samples late sees garbage
  assign io_rdata = io_req.re ? io[io_req.addr] : ~io[io_req.addr];

  always @(posedge ref_clk) begin
    if (io_req.we) io[io_req.addr] <= io_req.wdata;
  end
endmodule // cdp_mem_model

`default_nettype wire

// >>> sim/cdp_core_assertions.sv
// Port-level checks of flags, interrupt entry, fetch and I/O strobes of the core.
// Assumes one clock and a synchronous active-low reset; bound into every core.
`default_nettype none

module cdp_core_checker #(
  parameter int PC_W        = cdp_pkg::PC_W,
  parameter int STACK_DEPTH = cdp_pkg::STACK_DEPTH
) (
  input wire logic                 ref_clk,
  input wire logic                 resetn,
  input wire logic [PC_W-1:0]      pm_addr,
  input wire logic [15:0]          pm_rdata,
  input wire cdp_pkg::cdp_io_req_s io_req,
  input wire logic [7:0]           io_rdata,
  input wire logic                 irq_req,
  input wire logic [PC_W-1:0]      irq_vector,
  input wire logic                 irq_ack,
  input wire cdp_pkg::cdp_flags_s  cpu_flags,
  input wire logic [PC_W-1:0]      program_counter
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_vector_entry;
    (pm_addr == irq_vector) ##1 (program_counter == irq_vector);
  endsequence

  chk_sign_xor: assert property (cpu_flags.s == (cpu_flags.n ^ cpu_flags.v))
    else $error("sign flag differs from n xor v");
  chk_irq_gate: assert property (irq_ack |-> cpu_flags.i && irq_req)
    else $error("interrupt taken while disabled or not requested");
  chk_irq_clear: assert property (irq_ack |=> !cpu_flags.i && !irq_ack)
    else $error("interrupt enable not cleared on entry");
  chk_irq_vector: assert property (irq_ack |=> s_vector_entry)
    else $error("vector not fetched and executed after entry");
  chk_flags_internal: assert property (io_req.addr == cdp_pkg::IO_FLAGS_ADDR |->
    !io_req.we && !io_req.re) else $error("flag location leaked to the I/O bus");
  chk_reset_value: assert property ($rose(resetn) |->
    cpu_flags == cdp_pkg::FLAGS_RESET && pm_addr == cdp_pkg::PC_RESET)
    else $error("flags or fetch address not cleared by reset");
  chk_fetch_overlap: assert property ($changed(program_counter) |->
    program_counter == $past(pm_addr)) else $error("executed word was not the one fetched");
  chk_bit_range: assert property (io_req.re && io_req.we |-> io_req.addr <= 6'h1F)
    else $error("bit access outside the low I/O range");
endmodule // cdp_core_checker

bind cdp_core cdp_core_checker #(.PC_W(PC_W), .STACK_DEPTH(STACK_DEPTH)) cdp_core_checker_i (
  .ref_clk(ref_clk), .resetn(resetn), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
  .io_req(io_req), .io_rdata(io_rdata), .irq_req(irq_req), .irq_vector(irq_vector),
  .irq_ack(irq_ack), .cpu_flags(cpu_flags), .program_counter(program_counter));

`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench: small programs run from the memory model, results read back.
// Assumes the core contract of one fetch per cycle and same-cycle memory answers.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 ref_clk    = 1'b0;
  logic                 resetn     = 1'b0;
  logic                 irq_req    = 1'b0;
  logic [8:0]           irq_vector = 9'h100;
  logic [8:0]           pm_addr;
  logic [15:0]          pm_rdata;
  cdp_pkg::cdp_io_req_s io_req;
  logic [7:0]           io_rdata;
  logic                 irq_ack;
  cdp_pkg::cdp_flags_s  cpu_flags;
  logic [8:0]           program_counter;
  int                   err_total  = 0;
  int                   checks     = 0;
  logic [5:0]           wlog [$];

  always #12.5 ref_clk = ~ref_clk;

  // Mid-cycle sampling keeps the write log clear of edge races
  always @(negedge ref_clk) begin
    if (resetn && io_req.we) wlog.push_back(io_req.addr);
  end

  cdp_core cdp_core_i (
    .ref_clk(ref_clk), .resetn(resetn), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
    .io_req(io_req), .io_rdata(io_rdata), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_ack(irq_ack), .cpu_flags(cpu_flags), .program_counter(program_counter));

  cdp_mem_model mem_model_i (
    .ref_clk(ref_clk), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
    .io_req(io_req), .io_rdata(io_rdata));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks=%0d mismatches=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Entries are {word address, instruction}; unused words hold a jump to self
  task automatic boot(input logic [24:0] prog [$], input int cycles);
    @(posedge ref_clk);
    resetn <= 1'b0;
    // Load only once reset has emptied the pipe, so no old store lands afterwards
    repeat (2) @(posedge ref_clk);
    foreach (mem_model_i.mem[a]) mem_model_i.mem[a] = 16'hCFFF;
    foreach (mem_model_i.io[a]) mem_model_i.io[a] = 8'h00;
    foreach (prog[i]) mem_model_i.mem[prog[i][24:16]] = prog[i][15:0];
    wlog.delete();
    repeat (14) @(posedge ref_clk);
    resetn <= 1'b1;
    @(negedge ref_clk);
    check(cpu_flags, 16'h0000);
    repeat (cycles) @(negedge ref_clk);
  endtask

  task automatic check_log(input logic [5:0] exp [$]);
    foreach (exp[i]) check(wlog[i], exp[i]);
  endtask

  task automatic t_alu();
    boot('{{9'd0, 16'hE07F}, {9'd1, 16'hE101}, {9'd2, 16'h0211}, {9'd3, 16'h1C10},
           {9'd4, 16'h98B0}, {9'd5, 16'h98C0}, {9'd6, 16'hA083}}, 20);
    check(mem_model_i.io[5], 16'h0080);
    check(mem_model_i.io[6], 16'h0080);
    check(mem_model_i.io[4], 16'h0008);
    check(cpu_flags, 16'h002C);
    $display("test alu done");
  endtask

  task automatic t_stack();
    boot('{{9'd0, 16'hD009}, {9'd10, 16'hD009}, {9'd20, 16'hD009}, {9'd30, 16'hD009},
           {9'd40, 16'h9880}, {9'd41, 16'h8800}, {9'd31, 16'h98A0}, {9'd32, 16'h8800},
           {9'd21, 16'h98C0}, {9'd22, 16'h8800}, {9'd11, 16'h98E0}, {9'd12, 16'h8800}}, 60);
    check_log('{6'h04, 6'h05, 6'h06, 6'h07, 6'h07});
    $display("test stack done");
  endtask

  task automatic t_wrap();
    boot('{{9'd0, 16'hC1FE}, {9'd511, 16'hC005}, {9'd5, 16'h9AC0}, {9'd6, 16'hCFFD},
           {9'd4, 16'h9AE0}}, 25);
    check_log('{6'h16, 6'h17, 6'h16});
    $display("test wrap done");
  endtask

  task automatic t_pointer();
    boot('{{9'd0, 16'hEE03}, {9'd1, 16'hEF00}, {9'd2, 16'h8510}, {9'd3, 16'h9890},
           {9'd4, 16'hEFAB}, {9'd5, 16'hEE11}, {9'd6, 16'hE15A}, {9'd7, 16'h8312},
           {9'd8, 16'h98B2}}, 25);
    check(mem_model_i.io[4], 16'h00EF);
    check(mem_model_i.io[5], 16'h005A);
    $display("test pointer done");
  endtask

  task automatic t_irq();
    int n;
    @(posedge ref_clk);
    irq_req <= 1'b1;
    boot('{{9'd0, 16'hE080}, {9'd1, 16'h9FF0}, {9'h100, 16'h9910}, {9'h101, 16'h8900}}, 0);
    for (n = 0; n < 50 && irq_ack !== 1'b1; n++) @(negedge ref_clk);
    if (n == 50) begin
      err_total++;
      results();
    end
    check(cpu_flags, 16'h0080);
    @(posedge ref_clk);
    irq_req <= 1'b0;
    @(negedge ref_clk);
    check(cpu_flags, 16'h0000);
    repeat (20) @(negedge ref_clk);
    check(mem_model_i.io[8], 16'h0080);
    check(cpu_flags, 16'h0080);
    $display("test irq done");
  endtask

  initial begin
    t_alu();
    t_stack();
    t_wrap();
    t_pointer();
    t_irq();
    results();
  end
endmodule // testbench

`default_nettype wire
